/* msp_pkg.sv */
// Types shared by the multi slice modulator
package msp_pkg;
    typedef enum logic [2:0] {
        MSP_LEFT   = 3'h0,
        MSP_RIGHT  = 3'h1,
        MSP_CENTER = 3'h2,
        MSP_VAR    = 3'h3,
        MSP_PULSE  = 3'h4,
        MSP_TOGGLE = 3'h5
    } msp_mode_e;
    typedef logic [15:0] msp_word_t;
endpackage : msp_pkg

/* msp_pwm.sv */
// Multi slice PWM with compare modes behind an APB slave
`timescale 1ns/1ps
`include "msp_regs.svh"

module msp_pwm
    import msp_pkg::*;
#(
    parameter int NUM_SLICES = 4
) (
    // Clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  sys_rst_in,
    // APB slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [11:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // Slice outputs
    output logic      [NUM_SLICES-1:0] slice_first_output_out,
    output logic      [NUM_SLICES-1:0] slice_second_output_out
);

    localparam int NS = NUM_SLICES;

    // Software registers
    logic                 en_r;
    logic                 buffer_load_request_r;
    logic                 period_interrupt_flag_r;
    logic [7:0]           prescale_r;
    msp_word_t            period_value_r;
    logic [NS-1:0]        first_output_invert_r;
    logic [NS-1:0]        second_output_invert_r;
    logic [NS-1:0]        push_pull_enable_r;
    logic [NS-1:0][2:0]   mode_r;
    msp_word_t [NS-1:0]   first_duty_parameter_r;
    msp_word_t [NS-1:0]   second_duty_parameter_r;
    // Working buffers
    msp_word_t            period_buf_r;
    msp_word_t [NS-1:0]   p1_buf_r;
    msp_word_t [NS-1:0]   p2_buf_r;
    // Time base
    logic                 en_d_r;
    logic [7:0]           pre_cnt_r;
    msp_word_t            timer_r;
    logic                 half_r;
    logic                 pp_phase_r;
    logic [NS-1:0]        var_r;
    logic [NS-1:0]        tog1_r;
    logic [NS-1:0]        tog2_r;
    logic [NS-1:0]        act1;
    logic [NS-1:0]        act2;
    logic                 tick;
    logic                 period_end;
    logic                 en_rise;
    // APB decode
    logic                 acc;
    logic                 wr;
    logic                 mapped;
    logic [31:0]          rd_val;

    assign acc = psel_in && penable_in;
    assign wr  = acc && pready_out && pwrite_in;

    // APB: one wait state, registered answer
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= acc && !pready_out;
            pslverr_out <= acc && !pready_out && !mapped;
            if (acc && !pready_out && !pwrite_in)
                prdata_out <= rd_val;
            else if (pready_out)
                prdata_out <= 32'h0;
        end
    end

    // Read mux and address map
    always_comb begin
        rd_val = 32'h0;
        mapped = 1'b1;
        case (paddr_in)
            `MSP_OFF_CTRL: begin
                rd_val[`MSP_CTRL_EN]  = en_r;
                rd_val[`MSP_CTRL_LD]  = buffer_load_request_r;
                rd_val[`MSP_CTRL_PIF] = period_interrupt_flag_r;
                rd_val[`MSP_CTRL_PRE_LSB +: 8] = prescale_r;
            end
            `MSP_OFF_PERIOD: rd_val[15:0] = period_value_r;
            `MSP_OFF_OUTCFG: begin
                for (int i = 0; i < NS; i++) begin
                    rd_val[2*i]   = first_output_invert_r[i];
                    rd_val[2*i+1] = second_output_invert_r[i];
                end
                rd_val[`MSP_OUTCFG_PP_LSB +: NS] = push_pull_enable_r;
            end
            `MSP_OFF_MODE: rd_val[3*NS-1:0] = mode_r;
            `MSP_OFF_STATUS: begin
                rd_val[15:0]          = timer_r;
                rd_val[`MSP_STAT_RUN] = en_r;
            end
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < NS; i++) begin
                    if (paddr_in == `MSP_OFF_PARAM
                        + 12'(i) * `MSP_PARAM_STRIDE) begin
                        mapped       = 1'b1;
                        rd_val[15:0] = first_duty_parameter_r[i];
                    end
                    if (paddr_in == `MSP_OFF_PARAM + 12'h004
                        + 12'(i) * `MSP_PARAM_STRIDE) begin
                        mapped       = 1'b1;
                        rd_val[15:0] = second_duty_parameter_r[i];
                    end
                end
            end
        endcase
    end

    // Control register with sticky period flag
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            en_r                    <= 1'b0;
            buffer_load_request_r   <= 1'b0;
            period_interrupt_flag_r <= 1'b0;
            prescale_r              <= `MSP_RST_PRE;
        end else begin
            if (wr && paddr_in == `MSP_OFF_CTRL) begin
                en_r       <= pwdata_in[`MSP_CTRL_EN];
                prescale_r <= pwdata_in[`MSP_CTRL_PRE_LSB +: 8];
            end
            // Load request clears itself once serviced
            if (period_end)
                buffer_load_request_r <= 1'b0;
            else if (wr && paddr_in == `MSP_OFF_CTRL
                     && pwdata_in[`MSP_CTRL_LD])
                buffer_load_request_r <= 1'b1;
            // Set wins over write-one-to-clear
            if (period_end)
                period_interrupt_flag_r <= 1'b1;
            else if (wr && paddr_in == `MSP_OFF_CTRL
                     && pwdata_in[`MSP_CTRL_PIF])
                period_interrupt_flag_r <= 1'b0;
        end
    end

    // Period, output and mode registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            period_value_r         <= `MSP_RST_PERIOD;
            first_output_invert_r  <= '0;
            second_output_invert_r <= '0;
            push_pull_enable_r     <= '0;
            mode_r                 <= '0;
        end else if (wr) begin
            if (paddr_in == `MSP_OFF_PERIOD)
                period_value_r <= pwdata_in[15:0];
            if (paddr_in == `MSP_OFF_OUTCFG) begin
                for (int i = 0; i < NS; i++) begin
                    first_output_invert_r[i]  <= pwdata_in[2*i];
                    second_output_invert_r[i] <= pwdata_in[2*i+1];
                end
                push_pull_enable_r <= pwdata_in[`MSP_OUTCFG_PP_LSB +: NS];
            end
            if (paddr_in == `MSP_OFF_MODE)
                mode_r <= pwdata_in[3*NS-1:0];
        end
    end

    // Parameter registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NS; i++) begin
                first_duty_parameter_r[i]  <= `MSP_RST_PARAM;
                second_duty_parameter_r[i] <= `MSP_RST_PARAM;
            end
        end else if (wr) begin
            for (int i = 0; i < NS; i++) begin
                if (paddr_in == `MSP_OFF_PARAM + 12'(i) * `MSP_PARAM_STRIDE)
                    first_duty_parameter_r[i] <= pwdata_in[15:0];
                if (paddr_in == `MSP_OFF_PARAM + 12'h004
                    + 12'(i) * `MSP_PARAM_STRIDE)
                    second_duty_parameter_r[i] <= pwdata_in[15:0];
            end
        end
    end

    assign en_rise    = en_r && !en_d_r;
    assign tick       = en_r && (pre_cnt_r >= prescale_r);
    assign period_end = tick && (timer_r == period_buf_r);

    // Double buffers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            en_d_r       <= 1'b0;
            period_buf_r <= `MSP_RST_PERIOD;
            p1_buf_r     <= '0;
            p2_buf_r     <= '0;
        end else begin
            en_d_r <= en_r;
            if (en_rise || (period_end && buffer_load_request_r)) begin
                period_buf_r <= period_value_r;
                p1_buf_r     <= first_duty_parameter_r;
                p2_buf_r     <= second_duty_parameter_r;
            end
        end
    end

    // Prescaler, period timer, center half and push-pull phase
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !en_r) begin
            pre_cnt_r  <= 8'h00;
            timer_r    <= 16'h0000;
            half_r     <= 1'b0;
            pp_phase_r <= 1'b0;
        end else begin
            pre_cnt_r <= tick ? 8'h00 : pre_cnt_r + 8'h01;
            if (period_end) begin
                timer_r    <= 16'h0000;
                half_r     <= !half_r;
                pp_phase_r <= !pp_phase_r;
            end else if (tick) begin
                timer_r <= timer_r + 16'h0001;
            end
        end
    end

    // Per-slice waveform logic
    for (genvar s = 0; s < NS; s++) begin : g_slice
        msp_mode_e   mode;
        logic        m1;
        logic        m2;
        logic [17:0] cpos;
        logic [17:0] cmid;
        logic [17:0] q1;
        logic [17:0] q2;
        logic        pp;

        assign mode = msp_mode_e'(mode_r[s]);
        assign m1   = timer_r == p1_buf_r[s];
        assign m2   = timer_r == p2_buf_r[s];
        assign cmid = {2'b00, period_buf_r} + 18'h1;
        assign cpos = half_r ? {2'b00, timer_r} + cmid
                             : {2'b00, timer_r};
        assign q1   = {2'b00, p1_buf_r[s]};
        assign q2   = {2'b00, p2_buf_r[s]};
        assign pp   = push_pull_enable_r[s]
                      && (mode == MSP_LEFT || mode == MSP_RIGHT);

        always_comb begin
            act1[s] = 1'b0;
            act2[s] = 1'b0;
            case (mode)
                MSP_LEFT: begin
                    act1[s] = timer_r < p1_buf_r[s];
                    act2[s] = timer_r < p2_buf_r[s];
                end
                MSP_RIGHT: begin
                    act1[s] = ({2'b00, timer_r} + q1) >= cmid;
                    act2[s] = ({2'b00, timer_r} + q2) >= cmid;
                end
                MSP_CENTER: begin
                    act1[s] = (cpos + q1 >= cmid)
                              && (cpos < cmid + q1);
                    act2[s] = (cpos + q2 >= cmid) && (cpos < cmid + q2);
                end
                MSP_VAR: begin
                    act1[s] = m1 ? 1'b1 : (m2 ? 1'b0 : var_r[s]);
                    act2[s] = act1[s];
                end
                MSP_PULSE: begin
                    act1[s] = m1;
                    act2[s] = m2;
                end
                MSP_TOGGLE: begin
                    act1[s] = tog1_r[s] ^ m1;
                    act2[s] = tog2_r[s] ^ m2;
                end
                default: begin
                    act1[s] = 1'b0;
                    act2[s] = 1'b0;
                end
            endcase
            // Alternate periods; over-range parameter fills its period
            if (pp) begin
                act1[s] = act1[s] && !pp_phase_r;
                act2[s] = act2[s] && pp_phase_r;
            end
        end

        // Match-driven state for variable and toggled modes
        always_ff @(posedge ref_clk_in) begin
            if (sys_rst_in || !en_r) begin
                var_r[s]  <= 1'b0;
                tog1_r[s] <= 1'b0;
                tog2_r[s] <= 1'b0;
            end else if (tick) begin
                var_r[s] <= act1[s];
                if (m1)
                    tog1_r[s] <= !tog1_r[s];
                if (m2)
                    tog2_r[s] <= !tog2_r[s];
            end
        end

        // Output stage with polarity applied except in reset, where both outputs are 0
        always_ff @(posedge ref_clk_in) begin
            if (sys_rst_in) begin
                slice_first_output_out[s]  <= 1'b0;
                slice_second_output_out[s] <= 1'b0;
            end else begin
                slice_first_output_out[s]  <= (en_r && act1[s])
                    ^ first_output_invert_r[s];
                slice_second_output_out[s] <= (en_r && act2[s])
                    ^ second_output_invert_r[s];
            end
        end
    end

endmodule : msp_pwm

/* msp_pwm_checker.sv */
// Port checker for the multi slice modulator
`timescale 1ns/1ps
`include "msp_regs.svh"
module msp_pwm_checker
    import msp_pkg::*;
#(
    parameter int NUM_SLICES = 4
) (
    // Clock and reset
    input wire logic                  ref_clk_in,
    input wire logic                  sys_rst_in,
    // APB
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic                  pwrite_in,
    input wire logic [11:0]           paddr_in,
    input wire logic [31:0]           pwdata_in,
    input wire logic [31:0]           prdata_out,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    // Slice outputs
    input wire logic [NUM_SLICES-1:0] slice_first_output_out,
    input wire logic [NUM_SLICES-1:0] slice_second_output_out
);
    localparam logic [11:0] PEND = 12'(32 + 8 * NUM_SLICES);
    logic                  en_r;
    logic [NUM_SLICES-1:0] inv1_r;
    logic [NUM_SLICES-1:0] inv2_r;
    logic                  wr_done;
    logic                  mapped;
    assign wr_done = psel_in && penable_in && pwrite_in && pready_out;
    assign mapped  = paddr_in[1:0] == 2'h0 && (paddr_in < 12'h014
                     || (paddr_in >= 12'h020 && paddr_in < PEND));
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            en_r <= 1'b0;
        end else if (wr_done && paddr_in == `MSP_OFF_CTRL) begin
            en_r <= pwdata_in[`MSP_CTRL_EN];
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            inv1_r <= '0;
            inv2_r <= '0;
        end else if (wr_done && paddr_in == `MSP_OFF_OUTCFG) begin
            for (int s = 0; s < NUM_SLICES; s++) begin
                inv1_r[s] <= pwdata_in[2*s];
                inv2_r[s] <= pwdata_in[2*s+1];
            end
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_READY_TWO:
        assert property (psel_in && !penable_in |-> ##2 pready_out)
        else $error("ready late");
    AST_READY_PULSE:
        assert property (pready_out |=> !pready_out) else $error("ready long");
    AST_READY_ACCESS:
        assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    AST_DECODE:
        assert property (pready_out |-> pslverr_out == !mapped)
        else $error("bad decode");
    AST_ERR_READY:
        assert property (pslverr_out |-> pready_out) else $error("stray err");
    AST_RDATA_IDLE:
        assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("rdata not zero");
    AST_RST_QUIET:
        assert property (disable iff (1'b0) sys_rst_in |=>
            slice_first_output_out == '0 && slice_second_output_out == '0)
        else $error("outputs live in reset");
    AST_IDLE_INVERT:
        assert property (!en_r [*2] |=> slice_first_output_out ==
            $past(inv1_r) && slice_second_output_out == $past(inv2_r))
        else $error("idle level wrong");
    COV_UNMAPPED: cover property (pslverr_out);
    COV_RUN: cover property ($rose(en_r));
    COV_OUT: cover property (en_r && $rose(slice_first_output_out[0]));
endmodule : msp_pwm_checker

bind msp_pwm msp_pwm_checker #(.NUM_SLICES(NUM_SLICES)) u_chk (
    .ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .slice_first_output_out, .slice_second_output_out
);

/* msp_regs.svh */
// Register offsets, field positions, widths and reset values
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH
`define MSP_OFF_CTRL      12'h000
`define MSP_OFF_PERIOD    12'h004
`define MSP_OFF_OUTCFG    12'h008
`define MSP_OFF_MODE      12'h00c
`define MSP_OFF_STATUS    12'h010
`define MSP_OFF_PARAM     12'h020
`define MSP_PARAM_STRIDE  12'h008
`define MSP_CTRL_EN       0
`define MSP_CTRL_LD       1
`define MSP_CTRL_PIF      2
`define MSP_CTRL_PRE_LSB  8
`define MSP_OUTCFG_PP_LSB 8
`define MSP_STAT_RUN      16
`define MSP_MODE_W        3
`define MSP_RST_PERIOD    16'h0000
`define MSP_RST_PARAM     16'h0000
`define MSP_RST_PRE       8'h00
`define MSP_RST_MODE      3'h0
`endif

/* tb_top.sv */
// Self-checking bench for the multi slice modulator
`timescale 1ns/1ps
`include "msp_regs.svh"
module tb_top;
    import msp_pkg::*;
    logic        ref_clk_in;
    logic        sys_rst_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [3:0]  o1;
    logic [3:0]  o2;
    logic [31:0] rdat;
    logic        rerr;
    int          num_errors;
    int          check_count;
    int          h1 [4];
    int          h2 [4];
    int          ov [4];
    int          rises;

    msp_pwm #(.NUM_SLICES(4)) dut (
        .ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .slice_first_output_out(o1), .slice_second_output_out(o2)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk_n(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            num_errors++;
            $display("[ERR] %0t count %0d want %0d", $time, got, exp);
        end
    endtask : chk_n

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk_in);
        end
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) begin
            num_errors++;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk32(rdat, exp);
    endtask : rd_chk

    task automatic setup(input logic [31:0] mode, input logic [31:0] cfg,
                         input logic [31:0] p3);
        logic [11:0] pa;
        wr(`MSP_OFF_CTRL, 32'h0);
        wr(`MSP_OFF_PERIOD, 32'h5);
        wr(`MSP_OFF_MODE, mode);
        wr(`MSP_OFF_OUTCFG, cfg);
        for (int s = 0; s < 4; s++) begin
            pa = 12'(`MSP_OFF_PARAM + s * `MSP_PARAM_STRIDE);
            wr(pa, s == 3 ? p3 : 32'h4);
            wr(pa + 12'h4, 32'h2);
        end
    endtask : setup

    task automatic meas(input int len);
        logic [3:0] prev;
        h1 = '{default: 0};
        h2 = '{default: 0};
        ov = '{default: 0};
        rises = 0;
        @(posedge ref_clk_in);
        prev = o1;
        repeat (len) begin
            @(posedge ref_clk_in);
            for (int s = 0; s < 4; s++) begin
                h1[s] += int'(o1[s] === 1'b1);
                h2[s] += int'(o2[s] === 1'b1);
                ov[s] += int'((o1[s] & o2[s]) === 1'b1);
            end
            rises += int'(o1[0] === 1'b1 && prev[0] === 1'b0);
            prev = o1;
        end
    endtask : meas

    task automatic run_chk(input int e [8]);
        for (int s = 0; s < 4; s++) begin
            chk_n(h1[s], e[s]);
            chk_n(h2[s], e[s+4]);
        end
    endtask : run_chk

    initial begin
        repeat (6000) @(posedge ref_clk_in);
        num_errors++;
        give_verdict();
    end

    initial begin
        sys_rst_in  = 1'b1;
        psel_in     = 1'b0;
        penable_in  = 1'b0;
        pwrite_in   = 1'b0;
        paddr_in    = 12'h000;
        pwdata_in   = 32'h0;
        num_errors  = 0;
        check_count = 0;
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(`MSP_OFF_PERIOD, 32'h0);
        rd_chk(`MSP_OFF_MODE, 32'h0);
        rd_chk(12'h100, 32'h0);
        chk32({31'h0, rerr}, 32'h1);
        wr(`MSP_OFF_OUTCFG, 32'ha5);
        repeat (2) @(posedge ref_clk_in);
        chk32({24'h0, o2, o1}, 32'hc3);
        $display("test reset and invert done");
        setup(32'h688, 32'h0, 32'h4);
        wr(`MSP_OFF_CTRL, 32'h1);
        repeat (24) @(posedge ref_clk_in);
        meas(60);
        run_chk('{40, 40, 40, 40, 20, 20, 20, 40});
        rd_chk(`MSP_OFF_CTRL, 32'h5);
        wr(`MSP_OFF_CTRL, 32'h0);
        wr(`MSP_OFF_CTRL, 32'h4);
        rd_chk(`MSP_OFF_CTRL, 32'h0);
        chk32({24'h0, o2, o1}, 32'h0);
        $display("test aligned modes done");
        setup(32'h22c, 32'hf00, 32'h6);
        wr(`MSP_OFF_CTRL, 32'h1);
        repeat (24) @(posedge ref_clk_in);
        meas(60);
        run_chk('{10, 30, 20, 30, 10, 30, 10, 10});
        chk_n(ov[2] + ov[3], 0);
        $display("test compare and push-pull done");
        setup(32'h0, 32'h0, 32'h4);
        wr(`MSP_OFF_CTRL, 32'h101);
        repeat (24) @(posedge ref_clk_in);
        wr(`MSP_OFF_PERIOD, 32'hb);
        meas(120);
        chk_n(rises, 10);
        wr(`MSP_OFF_CTRL, 32'h103);
        repeat (60) @(posedge ref_clk_in);
        meas(120);
        chk_n(rises, 5);
        $display("test prescale and load done");
        give_verdict();
    end
endmodule : tb_top
